// [rtl/iec_pkg.sv]
// Constants and types for the interrupt edge and enable control block
// Summary of operation
// - Edge bit 4 sets pin4 and converter trigger edge
// - Edge bit 3 sets pin3 and timer F edge
// - Edge bit 1 sets pin1 and timer C edge
// - Edge bit 2 sets pin2 edge alone
// - Edge bit 0 sets pin0 edge alone
// - Edge register top three bits read one
// - Enable one bit 7 gates timer A
// - Enable one bit 6 gates serial unit one
// - Enable one bit 5 gates all wakeup pins
// - Enable one bits 4..0 gate external pins
// - Enable two bit 7 gates direct transfer
// - Enable two bit 6 gates converter end
// - Enable two bit 5 is plain storage
// - Enable two bit 4 gates timer G
// - Enable two bit 3 gates timer F high
// - Enable two bit 2 gates timer F low
// - Enable two bit 1 gates timer C
// - Enable two bit 0 gates event counter
// - Flags clear only by writing zero
// - Global mask blocks acceptance, not flag setting
// - Acceptance does not clear a flag
// - Highest fixed priority source presented first
package iec_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam logic [3:0] OFS_EDGE = 4'h0;
   localparam logic [3:0] OFS_EN_ONE = 4'h1;
   localparam logic [3:0] OFS_EN_TWO = 4'h2;
   localparam logic [3:0] OFS_FLAG_ONE = 4'h3;
   localparam logic [3:0] OFS_FLAG_TWO = 4'h4;
   localparam logic [3:0] OFS_PENDING = 4'h5;
   localparam logic [7:0] EDGE_FIXED_ONES = 8'hE0;
   localparam logic [7:0] EDGE_RESET = 8'hE0;
   localparam logic [7:0] EN_RESET = 8'h00;
   localparam logic [7:0] FLAG_ONE_FIXED = 8'h20;
   localparam logic [7:0] FLAG_RESET = 8'h00;
   localparam int unsigned BIT_SEL_PIN4 = 4;
   localparam int unsigned BIT_SEL_PIN3 = 3;
   localparam int unsigned BIT_SEL_PIN1 = 1;
   localparam int unsigned BIT_TIMER_A = 7;
   localparam int unsigned BIT_SERIAL_ONE = 6;
   localparam int unsigned BIT_WAKEUP = 5;
   localparam int unsigned BIT_DIRECT = 7;
   localparam int unsigned BIT_CONVERTER = 6;
   localparam int unsigned BIT_RESERVED_TWO = 5;
   localparam int unsigned NUM_SRC = 16;
   localparam logic [4:0] NO_VECTOR = 5'h00;
   // Vector numbers in fixed priority order, highest first
   localparam logic [4:0] VEC_PIN0 = 5'h04;
   localparam logic [4:0] VEC_WAKEUP = 5'h09;
   localparam logic [4:0] VEC_SERIAL_ONE = 5'h0A;
   localparam logic [4:0] VEC_TIMER_A = 5'h0B;
   localparam logic [4:0] VEC_EVENT_CNT = 5'h0C;
   localparam logic [4:0] VEC_TIMER_C = 5'h0D;
   localparam logic [4:0] VEC_TIMER_FL = 5'h0E;
   localparam logic [4:0] VEC_TIMER_FH = 5'h0F;
   localparam logic [4:0] VEC_TIMER_G = 5'h10;
   localparam logic [4:0] VEC_CONVERTER = 5'h13;
   localparam logic [4:0] VEC_DIRECT = 5'h14;
endpackage

// [rtl/iec_edge_det.sv]
// Synchronised edge detector with selectable polarity, one per input
`timescale 1ns/1ps
module iec_edge_det #(
   parameter int unsigned N = 8
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [N-1:0] pin_i,
   input wire logic [N-1:0] rising_i,
   output logic [N-1:0] edge_o
);
   logic [N-1:0] meta_q, meta_d;
   logic [N-1:0] sync_q, sync_d;
   logic [N-1:0] last_q, last_d;
   logic [N-1:0] edge_q, edge_d;
   genvar g;
   // Two stages before use; meta_q is read only by sync_q
   always_comb begin
      meta_d = pin_i;
      sync_d = meta_q;
      last_d = sync_q;
   end
   generate
      for (g = 0; g < N; g++) begin : g_bit
         always_comb begin
            edge_d[g] = rising_i[g] ? (sync_q[g] & ~last_q[g]) : (~sync_q[g] & last_q[g]);
         end
      end
   endgenerate
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta_q <= '1;
         sync_q <= '1;
         last_q <= '1;
         edge_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         last_q <= last_d;
         edge_q <= edge_d;
      end
   end
   assign edge_o = edge_q;
endmodule

// [rtl/iec_top.sv]
// Interrupt edge select, enable, request flags and priority presentation
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module iec_top
   import iec_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [iec_pkg::ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic [4:0] ext_pin_i,
   input wire logic [7:0] wakeup_pin_i,
   input wire logic converter_trigger_pin_i,
   input wire logic timer_f_event_pin_i,
   input wire logic timer_c_event_pin_i,
   output logic converter_trigger_o,
   output logic timer_f_event_o,
   output logic timer_c_event_o,
   input wire logic [7:0] wakeup_rising_i,
   input wire logic timer_a_evt_i,
   input wire logic serial_one_evt_i,
   input wire logic event_counter_evt_i,
   input wire logic timer_c_evt_i,
   input wire logic timer_f_low_evt_i,
   input wire logic timer_f_high_evt_i,
   input wire logic timer_g_evt_i,
   input wire logic converter_evt_i,
   input wire logic direct_transfer_evt_i,
   input wire logic global_mask_i,
   output logic irq_req_o,
   output logic [4:0] irq_vector_o,
   output logic [7:0] wakeup_pending_o
);
   import iec_pkg::*;

   logic [7:0] edge_q, edge_d;
   logic [7:0] en1_q, en1_d;
   logic [7:0] en2_q, en2_d;
   logic [7:0] flag1_q, flag1_d;
   logic [7:0] flag2_q, flag2_d;
   logic [7:0] wake_q, wake_d;
   logic [7:0] rdata_q, rdata_d;
   logic irq_q, irq_d;
   logic [4:0] vec_q, vec_d;
   logic [15:0] det_pin, det_rise, det_edge;
   logic [7:0] set1, set2;
   logic [NUM_SRC-1:0] req;
   logic [4:0] req_vec [NUM_SRC];
   logic wr_edge, wr_en1, wr_en2, wr_f1, wr_f2, wr_wake;

   // Pins: ext 0..4, wakeup 5..12, trigger 13, timer F 14, timer C 15
   always_comb begin
      det_pin = {timer_c_event_pin_i, timer_f_event_pin_i, converter_trigger_pin_i, wakeup_pin_i, ext_pin_i};
      det_rise = {edge_q[BIT_SEL_PIN1], edge_q[BIT_SEL_PIN3], edge_q[BIT_SEL_PIN4],
                  wakeup_rising_i, edge_q[4:0]};
   end

   iec_edge_det #(.N(16)) u_det (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .pin_i(det_pin),
      .rising_i(det_rise),
      .edge_o(det_edge)
   );

   always_comb begin
      converter_trigger_o = det_edge[13];
      timer_f_event_o = det_edge[14];
      timer_c_event_o = det_edge[15];
   end

   always_comb begin
      wr_edge = wr_i && (addr_i == OFS_EDGE);
      wr_en1 = wr_i && (addr_i == OFS_EN_ONE);
      wr_en2 = wr_i && (addr_i == OFS_EN_TWO);
      wr_f1 = wr_i && (addr_i == OFS_FLAG_ONE);
      wr_f2 = wr_i && (addr_i == OFS_FLAG_TWO);
      wr_wake = wr_i && (addr_i == OFS_PENDING);
      set1 = {timer_a_evt_i, serial_one_evt_i, 1'b0, det_edge[4:0]};
      set2 = {direct_transfer_evt_i, converter_evt_i, 1'b0, timer_g_evt_i,
              timer_f_high_evt_i, timer_f_low_evt_i, timer_c_evt_i, event_counter_evt_i};
   end

   // Registers and sticky flags; a set in the clearing cycle wins
   always_comb begin
      edge_d = edge_q;
      en1_d = en1_q;
      en2_d = en2_q;
      if (wr_edge) begin
         edge_d = wdata_i | EDGE_FIXED_ONES;
      end
      if (wr_en1) begin
         en1_d = wdata_i;
      end
      if (wr_en2) begin
         en2_d = wdata_i;
      end
      // Writing 1 keeps a flag; only 0 clears it; acceptance never clears
      flag1_d = wr_f1 ? (flag1_q & wdata_i) : flag1_q;
      flag1_d = (flag1_d | set1) | FLAG_ONE_FIXED;
      flag2_d = wr_f2 ? (flag2_q & wdata_i) : flag2_q;
      flag2_d[BIT_RESERVED_TWO] = wr_f2 ? wdata_i[BIT_RESERVED_TWO] : flag2_q[BIT_RESERVED_TWO];
      flag2_d = flag2_d | set2;
      wake_d = wr_wake ? (wake_q & wdata_i) : wake_q;
      wake_d = wake_d | det_edge[12:5];
   end

   // Request lines in fixed priority order, index 0 highest
   always_comb begin
      req[0] = flag1_q[0] & en1_q[0];
      req[1] = flag1_q[1] & en1_q[1];
      req[2] = flag1_q[2] & en1_q[2];
      req[3] = flag1_q[3] & en1_q[3];
      req[4] = flag1_q[4] & en1_q[4];
      req[5] = (|wake_q) & en1_q[BIT_WAKEUP];
      req[6] = flag1_q[BIT_SERIAL_ONE] & en1_q[BIT_SERIAL_ONE];
      req[7] = flag1_q[BIT_TIMER_A] & en1_q[BIT_TIMER_A];
      req[8] = flag2_q[0] & en2_q[0];
      req[9] = flag2_q[1] & en2_q[1];
      req[10] = flag2_q[2] & en2_q[2];
      req[11] = flag2_q[3] & en2_q[3];
      req[12] = flag2_q[4] & en2_q[4];
      req[13] = flag2_q[BIT_CONVERTER] & en2_q[BIT_CONVERTER];
      req[14] = flag2_q[BIT_DIRECT] & en2_q[BIT_DIRECT];
      req[15] = 1'b0;
      req_vec[0] = VEC_PIN0;
      req_vec[1] = VEC_PIN0 + 5'h01;
      req_vec[2] = VEC_PIN0 + 5'h02;
      req_vec[3] = VEC_PIN0 + 5'h03;
      req_vec[4] = VEC_PIN0 + 5'h04;
      req_vec[5] = VEC_WAKEUP;
      req_vec[6] = VEC_SERIAL_ONE;
      req_vec[7] = VEC_TIMER_A;
      req_vec[8] = VEC_EVENT_CNT;
      req_vec[9] = VEC_TIMER_C;
      req_vec[10] = VEC_TIMER_FL;
      req_vec[11] = VEC_TIMER_FH;
      req_vec[12] = VEC_TIMER_G;
      req_vec[13] = VEC_CONVERTER;
      req_vec[14] = VEC_DIRECT;
      req_vec[15] = NO_VECTOR;
   end

   // Walk from lowest priority up so the highest pending one is kept
   always_comb begin
      vec_d = NO_VECTOR;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            vec_d = req_vec[i];
         end
      end
      irq_d = (|req) & ~global_mask_i;
      if (global_mask_i) begin
         vec_d = NO_VECTOR;
      end
   end

   // Read data stand one cycle after the strobe; unmapped reads zero
   always_comb begin
      rdata_d = 8'h00;
      if (rd_i) begin
         unique case (addr_i)
            OFS_EDGE: rdata_d = edge_q | EDGE_FIXED_ONES;
            OFS_EN_ONE: rdata_d = en1_q;
            OFS_EN_TWO: rdata_d = en2_q;
            OFS_FLAG_ONE: rdata_d = flag1_q;
            OFS_FLAG_TWO: rdata_d = flag2_q;
            OFS_PENDING: rdata_d = wake_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         edge_q <= EDGE_RESET;
         en1_q <= EN_RESET;
         en2_q <= EN_RESET;
         flag1_q <= FLAG_ONE_FIXED;
         flag2_q <= FLAG_RESET;
         wake_q <= FLAG_RESET;
         rdata_q <= 8'h00;
         irq_q <= 1'b0;
         vec_q <= NO_VECTOR;
      end else begin
         edge_q <= edge_d;
         en1_q <= en1_d;
         en2_q <= en2_d;
         flag1_q <= flag1_d;
         flag2_q <= flag2_d;
         wake_q <= wake_d;
         rdata_q <= rdata_d;
         irq_q <= irq_d;
         vec_q <= vec_d;
      end
   end

   assign rdata_o = rdata_q;
   assign irq_req_o = irq_q;
   assign irq_vector_o = vec_q;
   assign wakeup_pending_o = wake_q;

   AST_EDGE_TOP_ONES: assert property (@(posedge clk_i) disable iff (srst_i)
      rd_i && addr_i == OFS_EDGE |=> rdata_o[7:5] == 3'h7) else $error("edge top bits not one");
   AST_EDGE_WRITE: assert property (@(posedge clk_i) disable iff (srst_i)
      wr_i && addr_i == OFS_EDGE ##1 rd_i && addr_i == OFS_EDGE |=> rdata_o[4:0] == $past(wdata_i[4:0], 2))
      else $error("edge select not stored");
   AST_EN1_STORE: assert property (@(posedge clk_i) disable iff (srst_i)
      wr_i && addr_i == OFS_EN_ONE |=> en1_q == $past(wdata_i)) else $error("enable one not stored");
   AST_EN2_STORE: assert property (@(posedge clk_i) disable iff (srst_i)
      wr_i && addr_i == OFS_EN_TWO |=> en2_q == $past(wdata_i)) else $error("enable two not stored");
   AST_ONE_NO_SET: assert property (@(posedge clk_i) disable iff (srst_i)
      wr_i && addr_i == OFS_FLAG_ONE && !flag1_q[7] && !timer_a_evt_i |=> !flag1_q[7])
      else $error("write of one set a flag");
   AST_SET_WINS: assert property (@(posedge clk_i) disable iff (srst_i)
      timer_a_evt_i |=> flag1_q[7]) else $error("event lost");
   AST_NO_AUTOCLR: assert property (@(posedge clk_i) disable iff (srst_i)
      flag2_q[0] && !(wr_i && addr_i == OFS_FLAG_TWO) |=> flag2_q[0]) else $error("flag cleared alone");
   AST_MASK: assert property (@(posedge clk_i) disable iff (srst_i)
      global_mask_i |=> !irq_req_o) else $error("request while masked");
   AST_GATE: assert property (@(posedge clk_i) disable iff (srst_i)
      !global_mask_i && flag1_q[0] && en1_q[0] |=> irq_req_o && irq_vector_o == VEC_PIN0)
      else $error("highest source not presented");
   AST_NONE: assert property (@(posedge clk_i) disable iff (srst_i)
      (en1_q == 8'h00) && (en2_q == 8'h00) |=> !irq_req_o) else $error("request without enable");
   // Shared pins: pin change reaches the pulse three edges later if the select is left alone
   AST_CONV_FALL: assert property (@(posedge clk_i) disable iff (srst_i)
      $fell(converter_trigger_pin_i) && !edge_q[BIT_SEL_PIN4] && !wr_i ##1 !wr_i |-> ##2 converter_trigger_o)
      else $error("converter trigger falling edge missed");
   AST_TIMF_FALL: assert property (@(posedge clk_i) disable iff (srst_i)
      $fell(timer_f_event_pin_i) && !edge_q[BIT_SEL_PIN3] && !wr_i ##1 !wr_i |-> ##2 timer_f_event_o)
      else $error("timer F falling edge missed");
   AST_TIMF_WRONG: assert property (@(posedge clk_i) disable iff (srst_i)
      $rose(timer_f_event_pin_i) && !edge_q[BIT_SEL_PIN3] && !wr_i ##1 !wr_i |-> ##2 !timer_f_event_o)
      else $error("timer F pulse on unselected edge");
   AST_TIMC_RISE: assert property (@(posedge clk_i) disable iff (srst_i)
      $rose(timer_c_event_pin_i) && edge_q[BIT_SEL_PIN1] && !wr_i ##1 !wr_i |-> ##2 timer_c_event_o)
      else $error("timer C rising edge missed");
   AST_PIN2_FLAG: assert property (@(posedge clk_i) disable iff (srst_i)
      det_edge[2] |=> flag1_q[2]) else $error("pin 2 edge lost");
   AST_PIN0_FLAG: assert property (@(posedge clk_i) disable iff (srst_i)
      det_edge[0] |=> flag1_q[0]) else $error("pin 0 edge lost");
   AST_GATE_TA: assert property (@(posedge clk_i) disable iff (srst_i)
      !global_mask_i && flag1_q[BIT_TIMER_A] && en1_q[BIT_TIMER_A] |=> irq_req_o)
      else $error("timer A request not raised");
   AST_GATE_SER: assert property (@(posedge clk_i) disable iff (srst_i)
      !global_mask_i && flag1_q[BIT_SERIAL_ONE] && en1_q[BIT_SERIAL_ONE] |=> irq_req_o)
      else $error("serial request not raised");
   AST_GATE_WAKE: assert property (@(posedge clk_i) disable iff (srst_i)
      !global_mask_i && (|wake_q) && en1_q[BIT_WAKEUP] |=> irq_req_o)
      else $error("wakeup request not raised");
   AST_GATE_DT: assert property (@(posedge clk_i) disable iff (srst_i)
      !global_mask_i && flag2_q[BIT_DIRECT] && en2_q[BIT_DIRECT] |=> irq_req_o)
      else $error("direct transfer request not raised");
   AST_GATE_AD: assert property (@(posedge clk_i) disable iff (srst_i)
      !global_mask_i && flag2_q[BIT_CONVERTER] && en2_q[BIT_CONVERTER] |=> irq_req_o)
      else $error("converter request not raised");
   AST_GATE_TG: assert property (@(posedge clk_i) disable iff (srst_i)
      !global_mask_i && flag2_q[4] && en2_q[4] |=> irq_req_o) else $error("timer G request not raised");
   AST_GATE_FH: assert property (@(posedge clk_i) disable iff (srst_i)
      !global_mask_i && flag2_q[3] && en2_q[3] |=> irq_req_o) else $error("timer F high request not raised");
   AST_GATE_FL: assert property (@(posedge clk_i) disable iff (srst_i)
      !global_mask_i && flag2_q[2] && en2_q[2] |=> irq_req_o) else $error("timer F low request not raised");
   AST_GATE_TC: assert property (@(posedge clk_i) disable iff (srst_i)
      !global_mask_i && flag2_q[1] && en2_q[1] |=> irq_req_o) else $error("timer C request not raised");
   AST_GATE_EC: assert property (@(posedge clk_i) disable iff (srst_i)
      !global_mask_i && flag2_q[0] && en2_q[0] |=> irq_req_o) else $error("event counter request not raised");
   COV_REQ: cover property (@(posedge clk_i) disable iff (srst_i) irq_req_o);
   COV_PIN_EDGE: cover property (@(posedge clk_i) disable iff (srst_i) det_edge[0] ##1 flag1_q[0]);
   COV_CLEAR: cover property (@(posedge clk_i) disable iff (srst_i) flag1_q[7] ##1 !flag1_q[7]);
endmodule

// [test/iec_src_model.sv]
// Peripheral source model: one-cycle event pulses on command
`timescale 1ns/1ps
module iec_src_model (
   input wire logic clk_i,
   input wire logic [8:0] fire_i,
   output logic [8:0] evt_o
);
   // Registered so each pulse is one full cycle, as a real peripheral gives
   always_ff @(posedge clk_i) begin
      evt_o <= fire_i;
   end
endmodule

// [test/iec_top_tb.sv]
// Self-checking bench: register map, gating, mask, priority and pin edges
`timescale 1ns/1ps
module iec_top_tb;
   import iec_pkg::*;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic rd_q = 1'b0;
   logic gmask = 1'b0;
   logic irq;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic [7:0] rdata_o;
   logic [7:0] wk_pin = 8'hFF;
   logic [7:0] wk_pend;
   logic [4:0] ext_pin = 5'h1F;
   logic [4:0] vec;
   logic [2:0] shr_pin = 3'h7;
   logic [2:0] shr_evt;
   logic [8:0] fire = 9'h000;
   logic [8:0] evt;
   logic [7:0] exp_q[$];
   logic [31:0] r;
   int err_count = 0;
   int tests_run = 0;
   int pulses[3] = '{0, 0, 0};
   // Order: timer A, serial one, event counter, timer C, F low, F high, G, converter, direct
   logic [4:0] vec_t[9] = '{5'h0B, 5'h0A, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h13, 5'h14};
   logic [3:0] ereg_t[9] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2};
   int ebit_t[9] = '{7, 6, 0, 1, 2, 3, 4, 6, 7};
   logic [7:0] rst_t[7] = '{8'hE0, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};

   iec_src_model src (.clk_i(clk_i), .fire_i(fire), .evt_o(evt));
   iec_top dut (
      .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .ext_pin_i(ext_pin), .wakeup_pin_i(wk_pin),
      .converter_trigger_pin_i(shr_pin[2]), .timer_f_event_pin_i(shr_pin[1]), .timer_c_event_pin_i(shr_pin[0]),
      .converter_trigger_o(shr_evt[2]), .timer_f_event_o(shr_evt[1]), .timer_c_event_o(shr_evt[0]),
      .wakeup_rising_i(8'h00), .timer_a_evt_i(evt[0]), .serial_one_evt_i(evt[1]),
      .event_counter_evt_i(evt[2]), .timer_c_evt_i(evt[3]), .timer_f_low_evt_i(evt[4]),
      .timer_f_high_evt_i(evt[5]), .timer_g_evt_i(evt[6]), .converter_evt_i(evt[7]),
      .direct_transfer_evt_i(evt[8]), .global_mask_i(gmask), .irq_req_o(irq), .irq_vector_o(vec),
      .wakeup_pending_o(wk_pend)
   );

   always #50 clk_i = ~clk_i;

   task automatic chk(string what, logic [7:0] seen, logic [7:0] expv);
      tests_run++;
      if (seen !== expv) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, expv, seen);
      end
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(logic [3:0] a, logic [7:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_i);
      rd_i <= 1'b0;
   endtask

   task automatic pulse(logic [8:0] m);
      @(posedge clk_i);
      fire <= m;
      @(posedge clk_i);
      fire <= 9'h000;
      repeat (4) @(posedge clk_i);
   endtask

   task automatic chk_irq(logic [4:0] v);
      chk("irq", {7'h00, irq}, {7'h00, v != NO_VECTOR});
      chk("vector", {3'h0, vec}, {3'h0, v});
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge clk_i) begin
      if (rd_q && exp_q.size() > 0) begin
         chk("rdata", rdata_o, exp_q.pop_front());
      end
      rd_q <= rd_i;
      foreach (pulses[k]) begin
         if (shr_evt[k] === 1'b1) begin
            pulses[k]++;
         end
      end
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      complete_run();
   end

   initial begin
      r = $urandom(32'h483CC69C);
      repeat (8) @(posedge clk_i);
      srst_i <= 1'b0;
      foreach (rst_t[i]) rd(4'(i), rst_t[i]);
      for (int i = 0; i < 6; i++) begin
         r = $urandom();
         wr(OFS_EDGE, r[7:0]);
         rd(OFS_EDGE, r[7:0] | 8'hE0);
         wr(OFS_EN_ONE, r[15:8]);
         wr(OFS_EN_TWO, r[23:16]);
         rd(OFS_EN_ONE, r[15:8]);
         rd(OFS_EN_TWO, r[23:16]);
         wr(4'h9, r[31:24]);
         rd(4'h9, 8'h00);
      end
      // Write then read with no gap, as the bus allows
      @(posedge clk_i);
      addr_i <= OFS_EDGE;
      wdata_i <= 8'h15;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      exp_q.push_back(8'hF5);
      @(posedge clk_i);
      rd_i <= 1'b0;
      wr(OFS_EDGE, 8'h00);
      foreach (vec_t[i]) begin
         wr(OFS_EN_ONE, 8'h00);
         wr(OFS_EN_TWO, 8'h00);
         pulse(9'h001 << i);
         chk_irq(NO_VECTOR);
         rd(ereg_t[i] + 4'h2, (ereg_t[i] == 4'h1 ? 8'h20 : 8'h00) | (8'h01 << ebit_t[i]));
         wr(ereg_t[i], 8'h01 << ebit_t[i]);
         repeat (2) @(posedge clk_i);
         chk_irq(vec_t[i]);
         gmask <= 1'b1;
         repeat (2) @(posedge clk_i);
         chk_irq(NO_VECTOR);
         gmask <= 1'b0;
         wr(ereg_t[i] + 4'h2, 8'hFF);
         repeat (2) @(posedge clk_i);
         chk_irq(vec_t[i]);
         wr(ereg_t[i] + 4'h2, 8'h00);
         repeat (2) @(posedge clk_i);
         chk_irq(NO_VECTOR);
      end
      wr(OFS_EN_ONE, 8'hFF);
      wr(OFS_EN_TWO, 8'hFF);
      pulse(9'h1FC);
      chk_irq(VEC_EVENT_CNT);
      wr(OFS_FLAG_TWO, 8'h7E);
      rd(OFS_FLAG_TWO, 8'h7E);
      chk_irq(VEC_TIMER_C);
      wr(OFS_FLAG_TWO, 8'h00);
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 5; i++) begin
            // Only pin i sees the tested polarity, so a swapped bit shows
            wr(OFS_EDGE, p ? 8'h01 << i : 8'h1F & ~(8'h01 << i));
            ext_pin[i] <= ~p[0];
            repeat (8) @(posedge clk_i);
            chk_irq(NO_VECTOR);
            ext_pin[i] <= p[0];
            repeat (8) @(posedge clk_i);
            chk_irq(VEC_PIN0 + 5'(i));
            wr(OFS_FLAG_ONE, 8'h00);
         end
         // In the rising pass only timer C selects rising, so a swapped select bit shows
         wr(OFS_EDGE, p ? 8'h02 : 8'h00);
         shr_pin <= {3{p[0]}};
         repeat (8) @(posedge clk_i);
         foreach (pulses[k]) chk("shared edge", 8'(pulses[k]), (p == 1 && k == 0) ? 8'h02 : 8'h01);
      end
      wk_pin[3] <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk("wakeup", wk_pend, 8'h08);
      chk_irq(VEC_WAKEUP);
      rd(OFS_PENDING, 8'h08);
      wr(OFS_PENDING, 8'hF7);
      repeat (2) @(posedge clk_i);
      chk("wakeup", wk_pend, 8'h00);
      srst_i <= 1'b1;
      @(posedge clk_i);
      srst_i <= 1'b0;
      rd(OFS_EN_ONE, 8'h00);
      rd(OFS_EDGE, 8'hE0);
      complete_run();
   end
endmodule
